/* File: design/mac_slice_regs.svh */
/*
 * constants for the multiply-accumulate slice: widths, accumulator reset value, xor width.
 * assumes inclusion from the slice package and design modules.
 */
`ifndef MAC_SLICE_REGS_SVH
`define MAC_SLICE_REGS_SVH
`define MAC_A_W 27
`define MAC_B_W 18
`define MAC_ACC_W 48
`define MAC_LANE24_W 24
`define MAC_LANE12_W 12
`define MAC_XOR_W 96
`define MAC_ACC_RST 48'h000000000000
`endif

/* File: design/mac_slice_pkg.sv */
/*
 * types for the multiply-accumulate slice.
 * assumes mac_slice_regs.svh is on the include path.
 */
`include "mac_slice_regs.svh"
package mac_slice_pkg;
    typedef enum logic [1:0] {
        LANE_ONE48 = 2'b00,
        LANE_TWO24 = 2'b01,
        LANE_FOUR12 = 2'b10
    } lane_mode_t;
    typedef enum logic [2:0] {
        ALU_ADD = 3'b000,
        ALU_SUB = 3'b001,
        ALU_ACC_ADD = 3'b010,
        ALU_ACC_SUB = 3'b011,
        ALU_COUNT_UP = 3'b100,
        ALU_COUNT_DN = 3'b101,
        ALU_LOGIC = 3'b110
    } alu_op_t;
    typedef enum logic [3:0] {
        LOG_AND = 4'h0,
        LOG_OR = 4'h1,
        LOG_XOR = 4'h2,
        LOG_NAND = 4'h3,
        LOG_NOR = 4'h4,
        LOG_XNOR = 4'h5,
        LOG_ANDN = 4'h6,
        LOG_ORN = 4'h7,
        LOG_NOTX = 4'h8,
        LOG_PASSX = 4'h9
    } logic_fn_t;
    typedef enum logic [1:0] {
        XW_12 = 2'b00,
        XW_24 = 2'b01,
        XW_48 = 2'b10,
        XW_96 = 2'b11
    } xor_width_t;
    typedef struct packed {
        logic [`MAC_A_W-1:0] a;
        logic [`MAC_A_W-1:0] d;
        logic [`MAC_B_W-1:0] b;
        logic [`MAC_ACC_W-1:0] x;
        logic [`MAC_ACC_W-1:0] y;
        logic [`MAC_ACC_W-1:0] pattern;
        logic [`MAC_ACC_W-1:0] pmask;
    } mac_operands_t;
    typedef struct packed {
        logic enable;
        logic bypass_mult;
        logic use_preadd;
        lane_mode_t lanes;
        alu_op_t op;
        logic_fn_t fn;
        xor_width_t xw;
    } mac_ctrl_t;
endpackage

/* File: design/mac_logic_unit.sv */
/*
 * bitwise logic unit of the slice: ten selectable functions, eight of x and y, two of x alone.
 * assumes the caller registers the result.
 */
`timescale 1ns/1ps
`include "mac_slice_regs.svh"
module mac_logic_unit
    import mac_slice_pkg::*;
#(
    parameter int W = `MAC_ACC_W
) (
    input wire logic [W-1:0] x,
    input wire logic [W-1:0] y,
    input wire logic_fn_t fn,
    output logic [W-1:0] r
);
    always_comb begin
        unique case (fn)
            LOG_AND: r = x & y;
            LOG_OR: r = x | y;
            LOG_XOR: r = x ^ y;
            LOG_NAND: r = ~(x & y);
            LOG_NOR: r = ~(x | y);
            LOG_XNOR: r = ~(x ^ y);
            LOG_ANDN: r = x & ~y;
            LOG_ORN: r = x | ~y;
            LOG_NOTX: r = ~x;
            LOG_PASSX: r = x;
            default: r = '0; // codes 10..15 are illegal
        endcase
    end
endmodule // mac_logic_unit

/* File: design/mac_slice.sv */
/*
 * multiply-accumulate slice: pre-adder, signed multiplier, split-lane
 * accumulator, logic unit, wide xor and pattern detector.
 * assumes operands and controls arrive synchronous to sys_clk each cycle.
 */
`timescale 1ns/1ps
`include "mac_slice_regs.svh"
module mac_slice
    import mac_slice_pkg::*;
#(
    parameter int ACC_W = `MAC_ACC_W
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire mac_operands_t opnd,
    input wire mac_ctrl_t ctrl,
    input wire logic [`MAC_XOR_W-1:0] xor_in,
    output logic [ACC_W-1:0] acc_q,
    output logic [3:0] carry_q,
    output logic [7:0] xor_par_q,
    output logic pat_match_q,
    output logic pat_bmatch_q,
    output logic wide_match_q
);
    localparam int PW = `MAC_A_W + `MAC_B_W;

    logic signed [`MAC_A_W:0] pre_sum;
    logic signed [PW:0] product;
    logic [ACC_W-1:0] mul_ext;
    logic [ACC_W-1:0] opnd_x;
    logic [ACC_W-1:0] opnd_y;
    logic [ACC_W-1:0] arith_d;
    logic [3:0] carry_d;
    logic [ACC_W-1:0] logic_r;
    logic [ACC_W-1:0] acc_d;
    logic [7:0] par12;
    logic [7:0] xor_d;
    logic [ACC_W-1:0] pat_diff;
    logic logic_mode_q;

    // the pre-adder is one bit wider so d+a cannot overflow before multiply
    always_comb begin
        if (ctrl.use_preadd) begin
            pre_sum = $signed({opnd.d[`MAC_A_W-1], opnd.d}) + $signed({opnd.a[`MAC_A_W-1], opnd.a});
        end else begin
            pre_sum = $signed({opnd.a[`MAC_A_W-1], opnd.a});
        end
        product = pre_sum * $signed(opnd.b);
        mul_ext = ACC_W'(product);
    end

    // operand select: product or bypassed 48-bit x
    always_comb begin
        opnd_x = ctrl.bypass_mult ? opnd.x : mul_ext;
        unique case (ctrl.op)
            ALU_ACC_ADD, ALU_ACC_SUB: opnd_y = acc_q;
            ALU_COUNT_UP, ALU_COUNT_DN: opnd_y = acc_q;
            default: opnd_y = opnd.y;
        endcase
    end

    // lane adder; each 12-bit segment either chains or cuts the carry
    function automatic logic cut_at(input lane_mode_t m, input int seg);
        if (m == LANE_FOUR12) begin
            return 1'b1;
        end else if (m == LANE_TWO24) begin
            return (seg == 2);
        end
        return 1'b0;
    endfunction

    always_comb begin
        logic [12:0] s;
        logic c;
        logic sub;
        logic [11:0] xa;
        logic [11:0] xb;
        s = '0;
        c = 1'b0;
        xa = '0;
        xb = '0;
        sub = (ctrl.op == ALU_SUB) || (ctrl.op == ALU_ACC_SUB) || (ctrl.op == ALU_COUNT_DN);
        arith_d = '0;
        carry_d = '0;
        for (int i = 0; i < 4; i++) begin
            if (i == 0 || cut_at(ctrl.lanes, i)) begin
                c = sub;
            end
            xb = opnd_y[i*12 +: 12];
            if (ctrl.op == ALU_COUNT_UP || ctrl.op == ALU_COUNT_DN) begin
                xa = (i == 0 || cut_at(ctrl.lanes, i)) ? 12'h001 : 12'h000;
                // down count adds ~1 at lane start and all ones above it, plus the lane-start carry, so borrows ripple like carries
                xa = sub ? ~xa : xa;
                s = {1'b0, xb} + {1'b0, xa} + {12'h000, c};
            end else begin
                xa = sub ? ~opnd_x[i*12 +: 12] : opnd_x[i*12 +: 12];
                s = {1'b0, xb} + {1'b0, xa} + {12'h000, c};
            end
            arith_d[i*12 +: 12] = s[11:0];
            c = s[12];
            carry_d[i] = s[12];
        end
    end

    mac_logic_unit #(
        .W(ACC_W)
    ) u_logic (
        .x(opnd.x),
        .y(opnd.y),
        .fn(ctrl.fn),
        .r(logic_r)
    );

    assign acc_d = (ctrl.op == ALU_LOGIC) ? logic_r : arith_d;

    // accumulator holds when the slice is not enabled; fabric must pair controls with data
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            acc_q <= `MAC_ACC_RST;
            carry_q <= '0;
            logic_mode_q <= 1'b0;
        end else if (ctrl.enable) begin
            acc_q <= acc_d;
            carry_q <= carry_d;
            logic_mode_q <= (ctrl.op == ALU_LOGIC);
        end
    end

    // wide xor: 12-bit parities combined in groups of 2, 4 or 8 per selected width
    generate
        for (genvar g = 0; g < 8; g++) begin : g_par
            assign par12[g] = ^xor_in[g*12 +: 12];
        end
    endgenerate

    always_comb begin
        xor_d = '0;
        unique case (ctrl.xw)
            XW_12: xor_d = par12;
            XW_24: begin
                for (int k = 0; k < 4; k++) begin
                    xor_d[k] = par12[2*k] ^ par12[2*k+1];
                end
            end
            XW_48: begin
                xor_d[0] = ^par12[3:0];
                xor_d[1] = ^par12[7:4];
            end
            XW_96: xor_d[0] = ^par12;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            xor_par_q <= '0;
        end else if (ctrl.enable) begin
            xor_par_q <= xor_d;
        end
    end

    // detector looks at the registered accumulator; mask bits set mean ignore
    assign pat_diff = (acc_q ^ opnd.pattern) & ~opnd.pmask;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pat_match_q <= 1'b0;
            pat_bmatch_q <= 1'b0;
            wide_match_q <= 1'b0;
        end else begin
            pat_match_q <= (pat_diff == '0);
            pat_bmatch_q <= (((acc_q ^ ~opnd.pattern) & ~opnd.pmask) == '0);
            // a previous hit chained with a hit on this logic result gives a 96-bit compare
            wide_match_q <= (pat_diff == '0) && logic_mode_q && pat_match_q;
        end
    end

    property p_hold_disabled;
        @(posedge sys_clk) disable iff (sys_rst)
        !ctrl.enable |=> $stable(acc_q);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled) else $error("acc changed while disabled");

    property p_count_up;
        @(posedge sys_clk) disable iff (sys_rst)
        ctrl.enable && ctrl.op == ALU_COUNT_UP && ctrl.lanes == LANE_ONE48
        |=> acc_q == ACC_W'($past(acc_q) + 1);
    endproperty
    a_count_up: assert property (p_count_up) else $error("count up wrong");

    property p_count_dn;
        @(posedge sys_clk) disable iff (sys_rst)
        ctrl.enable && ctrl.op == ALU_COUNT_DN && ctrl.lanes == LANE_ONE48
        |=> acc_q == ACC_W'($past(acc_q) - 1);
    endproperty
    a_count_dn: assert property (p_count_dn) else $error("count down wrong");

    property p_bypass_add;
        @(posedge sys_clk) disable iff (sys_rst)
        ctrl.enable && ctrl.bypass_mult && ctrl.op == ALU_ADD && ctrl.lanes == LANE_ONE48
        |=> acc_q == ACC_W'($past(opnd.x) + $past(opnd.y));
    endproperty
    a_bypass_add: assert property (p_bypass_add) else $error("bypass add wrong");

    property p_mac;
        @(posedge sys_clk) disable iff (sys_rst)
        ctrl.enable && !ctrl.bypass_mult && !ctrl.use_preadd && ctrl.op == ALU_ACC_ADD
        && ctrl.lanes == LANE_ONE48
        |=> acc_q == ACC_W'($past(acc_q) + ACC_W'($signed($past(opnd.a)) * $signed($past(opnd.b))));
    endproperty
    a_mac: assert property (p_mac) else $error("multiply accumulate wrong");

    property p_lane12;
        @(posedge sys_clk) disable iff (sys_rst)
        ctrl.enable && ctrl.bypass_mult && ctrl.op == ALU_ADD && ctrl.lanes == LANE_FOUR12
        |=> acc_q[23:12] == 12'($past(opnd.x[23:12]) + $past(opnd.y[23:12]));
    endproperty
    a_lane12: assert property (p_lane12) else $error("lane carry leaked");

    property p_lane24;
        @(posedge sys_clk) disable iff (sys_rst)
        ctrl.enable && ctrl.bypass_mult && ctrl.op == ALU_ADD && ctrl.lanes == LANE_TWO24
        |=> acc_q[47:24] == 24'($past(opnd.x[47:24]) + $past(opnd.y[47:24]));
    endproperty
    a_lane24: assert property (p_lane24) else $error("upper 24 lane wrong");

    property p_xor96;
        @(posedge sys_clk) disable iff (sys_rst)
        ctrl.enable && ctrl.xw == XW_96 |=> xor_par_q == {7'h00, ^$past(xor_in)};
    endproperty
    a_xor96: assert property (p_xor96) else $error("xor 96 wrong");

    property p_pattern;
        @(posedge sys_clk) disable iff (sys_rst)
        (((acc_q ^ opnd.pattern) & ~opnd.pmask) == '0) |=> pat_match_q;
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern missed");

    // a hit on a logic result right after another hit joins two 48-bit compares into one
    sequence s_pat_hit;
        pat_diff == '0;
    endsequence

    sequence s_logic_hit;
        logic_mode_q && pat_diff == '0;
    endsequence

    property p_wide_match;
        @(posedge sys_clk) disable iff (sys_rst)
        s_pat_hit ##1 s_logic_hit |=> wide_match_q;
    endproperty
    a_wide_match: assert property (p_wide_match) else $error("wide match missed");
endmodule // mac_slice

/* File: dv/fabric_model.sv */
/*
 * fabric model: the logic around the slice that supplies operands and controls.
 * assumes the bench calls send from one thread at a time.
 */
`timescale 1ns/1ps
`include "mac_slice_regs.svh"
module fabric_model
    import mac_slice_pkg::*;
(
    input wire logic sys_clk,
    output mac_operands_t opnd,
    output mac_ctrl_t ctrl,
    output logic [`MAC_XOR_W-1:0] xor_in
);
    initial begin
        opnd = '0;
        ctrl = '0;
        xor_in = '0;
    end
    // operands and controls land on one edge, enable stays up for n edges
    task automatic send(input mac_operands_t o, input mac_ctrl_t c, input logic [95:0] xi, input int n);
        c.enable = 1'b1;
        @(posedge sys_clk);
        opnd <= o;
        ctrl <= c;
        xor_in <= xi;
        repeat (n) @(posedge sys_clk);
        ctrl.enable <= 1'b0;
    endtask
endmodule // fabric_model

/* File: dv/tb_dsp_multiply_accumulate_slice.sv */
/*
 * self-checking bench for the multiply-accumulate slice.
 * assumes fabric_model drives all slice inputs except clock and reset.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_dsp_multiply_accumulate_slice
    import mac_slice_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    mac_operands_t opnd, o;
    mac_ctrl_t ctrl, c;
    logic [95:0] xor_in, xi;
    logic [47:0] acc_q, r;
    logic [7:0] xor_par_q, ep;
    logic [3:0] carry_q;
    logic pat_match_q, pat_bmatch_q, wide_match_q;
    int miscompares = 0;
    int n_checks = 0;
    mac_slice i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .opnd(opnd), .ctrl(ctrl), .xor_in(xor_in),
        .acc_q(acc_q), .carry_q(carry_q), .xor_par_q(xor_par_q), .pat_match_q(pat_match_q),
        .pat_bmatch_q(pat_bmatch_q), .wide_match_q(wide_match_q));
    fabric_model i_fab (.sys_clk(sys_clk), .opnd(opnd), .ctrl(ctrl), .xor_in(xor_in));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish;
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic go(input int n);
        i_fab.send(o, c, xi, n);
        #1;
    endtask
    // reference functions in package code order; andn and orn invert the second operand
    function automatic logic [47:0] lf(input int f, input logic [47:0] x, y);
        case (f)
            0: return x & y;
            1: return x | y;
            2: return x ^ y;
            3: return ~(x & y);
            4: return ~(x | y);
            5: return ~(x ^ y);
            6: return x & ~y;
            7: return x | ~y;
            8: return ~x;
            9: return x;
            default: return '0;
        endcase
    endfunction
    task automatic t_mult;
        o = '0; c = '0; c.op = ALU_ADD; o.a = -27'sd3; o.b = 18'd5; o.y = 48'd10;
        go(1); `CHK(acc_q, 48'hfffffffffffb)
        c.op = ALU_ACC_ADD;
        go(1); `CHK(acc_q, 48'hffffffffffec)
        c.op = ALU_ADD; c.use_preadd = 1'b1; o.d = 27'd2;
        go(1); `CHK(acc_q, 48'h000000000005)
        c.op = ALU_ACC_SUB;
        go(1); `CHK(acc_q, 48'h00000000000a)
    endtask
    task automatic t_lanes;
        o = '0; c = '0; c.bypass_mult = 1'b1; c.op = ALU_SUB; o.x = 48'h1;
        go(1); `CHK(acc_q, 48'hffffffffffff)
        c.op = ALU_ADD; c.lanes = LANE_TWO24; o.x = 48'h000001000001; o.y = 48'h000000ffffff;
        go(1); `CHK(acc_q, 48'h000001000000)
        `CHK(carry_q, 4'h3)
        c.lanes = LANE_FOUR12; o.x = 48'h001001001001; o.y = 48'h000fff000fff;
        go(1); `CHK(acc_q, 48'h001000001000)
        `CHK(carry_q, 4'h5)
        c.op = ALU_COUNT_DN;
        go(1); `CHK(acc_q, 48'h000fff000fff)
        c.op = ALU_COUNT_UP; c.lanes = LANE_ONE48;
        go(3); `CHK(acc_q, 48'h000fff001002)
        repeat (2) @(posedge sys_clk);
        #1; `CHK(acc_q, 48'h000fff001002)
        c.op = ALU_COUNT_DN;
        go(3); `CHK(acc_q, 48'h000fff000fff)
    endtask
    task automatic t_logic;
        o = '0; c = '0; c.bypass_mult = 1'b1; c.op = ALU_LOGIC;
        o.x = 48'h0000ffff00ff; o.y = 48'h00ff00ff0f0f;
        for (int f = 0; f <= 10; f++) begin
            c.fn = logic_fn_t'(f);
            go(1);
            r = lf(f, o.x, o.y);
            `CHK(acc_q, r)
        end
    endtask
    task automatic t_xor;
        int seg;
        o = '0; c = '0; xi = 96'h0123456789abcdef0f1e2d3c;
        for (int w = 0; w < 4; w++) begin
            c.xw = xor_width_t'(w); seg = 12 << w; ep = '0;
            for (int i = 0; i < 96 / seg; i++) ep[i] = ^((xi >> (i * seg)) & ((96'd1 << seg) - 96'd1));
            go(1); `CHK(xor_par_q, ep)
        end
    endtask
    task automatic t_pattern;
        int k;
        o = '0; c = '0; c.bypass_mult = 1'b1; c.op = ALU_LOGIC; c.fn = LOG_PASSX;
        o.x = 48'h5a5a00c3c3ff; o.pattern = o.x;
        go(1);
        @(posedge sys_clk); #1;
        `CHK(pat_match_q, 1'b1)
        `CHK(pat_bmatch_q, 1'b0)
        k = 0;
        while (wide_match_q !== 1'b1 && k < 4) begin
            @(posedge sys_clk); #1; k++;
        end
        `CHK(wide_match_q, 1'b1)
        if (k == 4) tally_and_finish();
        c.op = ALU_ADD; o.x = '0; o.y = 48'h123456789abc; o.pattern = ~o.y ^ 48'h1; o.pmask = 48'h1;
        go(1);
        @(posedge sys_clk); #1;
        `CHK(pat_bmatch_q, 1'b1)
        `CHK(pat_match_q, 1'b0)
    endtask
    initial begin
        o = '0; c = '0; xi = '0;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1; `CHK(acc_q, 48'h0)
        t_mult();
        t_lanes();
        t_logic();
        t_xor();
        t_pattern();
        tally_and_finish();
    end
endmodule // tb_dsp_multiply_accumulate_slice
